/* File: verilog/refi_pkg.sv */
// constants of the rtc event flag and interrupt enable block
// assumes a byte wide register port with one cycle read latency
package refi_pkg;
  // register byte offsets
  localparam logic [7:0] STATUS_ADDR     = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h01;
  localparam logic [7:0] MASK_ADDR       = 8'h02;
  // status bit positions
  localparam int unsigned BIT_ALARM_ONE  = 0;
  localparam int unsigned BIT_ALARM_TWO  = 1;
  localparam int unsigned BIT_TIMER_ZERO = 2;
  localparam int unsigned BIT_TEMP_READY = 3;
  localparam int unsigned BIT_POWER_FAIL = 5;
  localparam int unsigned BIT_OSC_STOP   = 6;
  localparam int unsigned BIT_SUPPLY_BAT = 7;
  // enable register layout and reset values
  localparam logic [7:0] ENABLE_WR_MASK  = 8'h6F;
  localparam logic [7:0] ENABLE_RESET    = 8'h00;
  localparam logic [7:0] FLAG_RESET      = 8'h40;
  localparam logic [7:0] IRQ_SRC_MASK    = 8'h2F;
  localparam logic [7:0] MASK_RESET      = 8'hFF;
endpackage

/* File: verilog/refi_rdreg.sv */
// output register for read data
// assumes one clock and synchronous active low reset
`timescale 1ns/1ps
module refi_rdreg (
  input  wire logic       clk_sys, // system clock
  input  wire logic       nrst,    // sync reset, low
  input  wire logic [7:0] data_d,  // next read data
  output logic      [7:0] data_q   // registered read data
);
  // hold one cycle of read data
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      data_q <= 8'h00;
    end else begin
      data_q <= data_d;
    end
  end
endmodule

/* File: verilog/refi_event_irq.sv */
// event flags, enables and interrupt pin of the rtc core
// assumes event strobes synchronous to clk_sys, one cycle each
//
// Notes on behaviour
// - temp ready flag bit 3 set on one-shot conversion done
// - temp ready flag with its enable drives the interrupt pin
// - timer flag bit 2 set when countdown reaches zero
// - alarm two flag bit 1 set on alarm two match
// - alarm two flag with its enable drives the interrupt pin
// - enable bit 0 gates alarm one; alarm one flag is status bit 0
// - enable bit 6 set holds the oscillator stop flag at zero
// - enable bit 5 gates the power fail interrupt
// - enable bit 3 gates the temp ready interrupt
// - enable bit 2 gates the timer interrupt
// - enable bit 1 gates the alarm two interrupt
// - oscillator stop flag sets on halt, never drives the pin
`timescale 1ns/1ps
module refi_event_irq (
  input  wire logic       clk_sys,       // system clock, 100 MHz
  input  wire logic       nrst,          // sync reset, low
  input  wire logic [7:0] reg_addr,      // register address
  input  wire logic [7:0] reg_wdata,     // write data
  input  wire logic       reg_wr,        // write strobe
  input  wire logic       reg_rd,        // read strobe
  output logic      [7:0] reg_rdata,     // read data, next cycle
  input  wire logic       temp_done,     // one-shot conversion done
  input  wire logic       oneshot_mode,  // conversion in one-shot mode
  input  wire logic       timer_zero,    // countdown reached zero
  input  wire logic       alarm_two_hit, // alarm two match
  input  wire logic       alarm_one_hit, // alarm one match
  input  wire logic       power_fail,    // power fail event
  input  wire logic       osc_stopped,   // oscillator halted, level
  input  wire logic       on_battery,    // running from backup supply
  output logic            irq_n,         // interrupt pin, active low
  output logic            irq_oe         // pin drive enable, open drain
);
  // ****************************************
  // decode
  // ****************************************
  logic [7:0] flag_q, flag_d, en_q, en_d, mask_q, mask_d, set_vec, rd_d;
  logic       rd_status, wr_enable, wr_mask, irq_any;

  // status read is the clear event, so no write path to flags
  assign rd_status = reg_rd && (reg_addr == refi_pkg::STATUS_ADDR);
  assign wr_enable = reg_wr && (reg_addr == refi_pkg::IRQ_ENABLE_ADDR);
  assign wr_mask   = reg_wr && (reg_addr == refi_pkg::MASK_ADDR);

  // ****************************************
  // event set vector
  // ****************************************
  always_comb begin
    set_vec = 8'h00;
    set_vec[refi_pkg::BIT_TEMP_READY] = temp_done && oneshot_mode;
    set_vec[refi_pkg::BIT_TIMER_ZERO] = timer_zero;
    set_vec[refi_pkg::BIT_ALARM_TWO]  = alarm_two_hit;
    set_vec[refi_pkg::BIT_ALARM_ONE]  = alarm_one_hit;
    set_vec[refi_pkg::BIT_POWER_FAIL] = power_fail;
    // mask forces the stop flag low
    set_vec[refi_pkg::BIT_OSC_STOP] = osc_stopped &&
        !en_q[refi_pkg::BIT_OSC_STOP];
  end

  // set wins over the read clear; the stop mask also wipes a flag already set
  assign flag_d = ((rd_status ? 8'h00 : flag_q) | set_vec) &
                  ~(8'(en_q[refi_pkg::BIT_OSC_STOP]) << refi_pkg::BIT_OSC_STOP);
  assign en_d   = wr_enable ? (reg_wdata & refi_pkg::ENABLE_WR_MASK) : en_q;
  assign mask_d = wr_mask ? reg_wdata : mask_q;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flag_q <= refi_pkg::FLAG_RESET;
      en_q   <= refi_pkg::ENABLE_RESET;
      mask_q <= refi_pkg::MASK_RESET;
    end else begin
      flag_q <= flag_d;
      en_q   <= en_d;
      mask_q <= mask_d;
    end
  end

  // ****************************************
  // interrupt pin
  // ****************************************
  // stop flag excluded by source mask; extra mask is a second gate
  assign irq_any = |(flag_q & en_q & mask_q & refi_pkg::IRQ_SRC_MASK);
  assign irq_n   = !irq_any;
  assign irq_oe  = irq_any;

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    rd_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        refi_pkg::STATUS_ADDR: begin
          rd_d = flag_q;
          rd_d[refi_pkg::BIT_SUPPLY_BAT] = on_battery;
        end
        refi_pkg::IRQ_ENABLE_ADDR: rd_d = en_q;
        refi_pkg::MASK_ADDR:       rd_d = mask_q;
        default:                   rd_d = 8'h00;
      endcase
    end
  end

  refi_rdreg u_rdreg (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .data_d  (rd_d),
    .data_q  (reg_rdata)
  );

  // ****************************************
  // checks
  // ****************************************
  chk_temp_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    temp_done && oneshot_mode |=> flag_q[refi_pkg::BIT_TEMP_READY])
    else $error("temp ready flag not set");
  chk_timer_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    timer_zero |=> flag_q[refi_pkg::BIT_TIMER_ZERO])
    else $error("timer flag not set");
  chk_alarm2_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    alarm_two_hit |=> flag_q[refi_pkg::BIT_ALARM_TWO])
    else $error("alarm two flag not set");
  chk_alarm1_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    alarm_one_hit && en_q[refi_pkg::BIT_ALARM_ONE] && mask_q[refi_pkg::BIT_ALARM_ONE]
    && !wr_enable && !wr_mask |=> !irq_n)
    else $error("alarm one irq missing");
  chk_osc_mask: assert property (@(posedge clk_sys) disable iff (!nrst)
    en_q[refi_pkg::BIT_OSC_STOP] |=> !flag_q[refi_pkg::BIT_OSC_STOP])
    else $error("masked stop flag set");
  chk_osc_noirq: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_any |-> |(flag_q & en_q & refi_pkg::IRQ_SRC_MASK))
    else $error("stop flag drove irq");
  chk_read_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd_status && set_vec == 8'h00 |=> flag_q == 8'h00 ##0 irq_n)
    else $error("read did not clear");
  chk_read_data: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rd && reg_addr == refi_pkg::IRQ_ENABLE_ADDR |=> reg_rdata == $past(en_q))
    else $error("enable readback wrong");
  chk_en_reset: assert property (@(posedge clk_sys)
    !nrst |=> en_q == refi_pkg::ENABLE_RESET)
    else $error("enable not reset");
  chk_pin_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    (en_q & refi_pkg::IRQ_SRC_MASK) == 8'h00 |-> irq_n && !irq_oe)
    else $error("irq without enable");
endmodule

/* File: testbench/refi_host_model.sv */
// host side model that watches the open drain interrupt pin
// assumes a pull-up on the pin and the block's pin drive signals
`timescale 1ns/1ps
module refi_host_model (
  input  wire logic irq_n,   // pin value from the block
  input  wire logic irq_oe,  // block pulls the pin low
  output logic      pin_low  // host sees an interrupt
);
  // pull-up wins whenever the block lets go, so a stray low never counts
  assign pin_low = irq_oe & ~irq_n;
endmodule

/* File: testbench/tb.sv */
// self-checking bench of the event flag and interrupt block
// assumes refi_pkg compiled first; one 100 MHz clock
`timescale 1ns/1ps
module tb;
  logic        clk_sys, nrst, reg_wr, reg_rd, oneshot_mode, osc_stopped, on_bat;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ev;
  logic        irq_n, irq_oe, pin_low;
  int          errors, n_tests;
  // event byte (laid out as status bits) beside enable byte
  logic [15:0] rows [10] = '{16'h0101, 16'h0100, 16'h0202, 16'h0200, 16'h0404,
                             16'h0408, 16'h0808, 16'h0807, 16'h2020, 16'h2000};

  refi_event_irq i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temp_done(ev[3]), .oneshot_mode(oneshot_mode), .timer_zero(ev[2]),
    .alarm_two_hit(ev[1]), .alarm_one_hit(ev[0]), .power_fail(ev[5]),
    .osc_stopped(osc_stopped), .on_battery(on_bat), .irq_n(irq_n), .irq_oe(irq_oe));
  refi_host_model i_host (.irq_n(irq_n), .irq_oe(irq_oe), .pin_low(pin_low));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // one cycle pulse on the event strobes and the stop level
  task automatic pulse(input logic [7:0] e, input logic s);
    @(posedge clk_sys) begin ev <= e; osc_stopped <= s; end
    @(posedge clk_sys) begin ev <= '0; osc_stopped <= 1'b0; end
    #1;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a hang is cut short well past the expected run
  initial begin
    #20000;
    errors++;
    results();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    ev = '0; oneshot_mode = 1'b1; osc_stopped = 1'b0; errors = 0; n_tests = 0;
    on_bat = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(refi_pkg::IRQ_ENABLE_ADDR, 8'h00);
    rd(refi_pkg::STATUS_ADDR, 8'h40);
    foreach (rows[i]) begin
      wr(refi_pkg::IRQ_ENABLE_ADDR, rows[i][7:0]);
      pulse(rows[i][15:8], 1'b0);
      chk("pin", {7'd0, |(rows[i][15:8] & rows[i][7:0])}, {7'd0, pin_low});
      rd(refi_pkg::STATUS_ADDR, rows[i][15:8]);
      chk("pin clear", 8'h00, {7'd0, pin_low});
    end
    // writable bits only, and an unmapped place reads zero
    wr(refi_pkg::IRQ_ENABLE_ADDR, 8'hFF);
    rd(refi_pkg::IRQ_ENABLE_ADDR, 8'h6F);
    rd(8'h07, 8'h00);
    // temperature done outside one-shot mode leaves no flag
    oneshot_mode <= 1'b0;
    pulse(8'h08, 1'b0);
    chk("pin", 8'h00, {7'd0, pin_low});
    rd(refi_pkg::STATUS_ADDR, 8'h00);
    // stop flag sets but stays off the pin, then the mask holds it low
    wr(refi_pkg::IRQ_ENABLE_ADDR, 8'h2F);
    pulse(8'h00, 1'b1);
    chk("pin", 8'h00, {7'd0, pin_low});
    rd(refi_pkg::STATUS_ADDR, 8'h40);
    pulse(8'h00, 1'b1);
    wr(refi_pkg::IRQ_ENABLE_ADDR, 8'h40);
    pulse(8'h00, 1'b1);
    rd(refi_pkg::STATUS_ADDR, 8'h00);
    // extra mask register blocks the pin but not the flag
    wr(refi_pkg::IRQ_ENABLE_ADDR, 8'h01);
    wr(refi_pkg::MASK_ADDR, 8'h00);
    rd(refi_pkg::MASK_ADDR, 8'h00);
    pulse(8'h01, 1'b0);
    chk("pin masked", 8'h00, {7'd0, pin_low});
    rd(refi_pkg::STATUS_ADDR, 8'h01);
    wr(refi_pkg::MASK_ADDR, 8'hFF);
    // supply bit reads live in the status byte
    @(posedge clk_sys) on_bat <= 1'b1;
    rd(refi_pkg::STATUS_ADDR, 8'h80);
    @(posedge clk_sys) on_bat <= 1'b0;
    // reset in mid-run brings back reset values
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(refi_pkg::IRQ_ENABLE_ADDR, 8'h00);
    rd(refi_pkg::MASK_ADDR, 8'hFF);
    rd(refi_pkg::STATUS_ADDR, 8'h40);
    results();
  end
endmodule
